//--- hw/vpe_cfg.svh
`ifndef VPE_CFG_SVH
`define VPE_CFG_SVH

// ************************************************************
// clock and time base
// ************************************************************
`define VPE_CLK_PERIOD_NS  8
`define VPE_TICK_NS        100000000
`define VPE_TICK_CYCLES    (`VPE_TICK_NS / `VPE_CLK_PERIOD_NS)

// ************************************************************
// register byte offsets
// ************************************************************
`define VPE_OFS_CTRL       8'h00
`define VPE_OFS_STATUS     8'h04
`define VPE_OFS_NSV_BASE   8'h10
`define VPE_OFS_UV1_BASE   8'h20
`define VPE_OFS_UV2_BASE   8'h30
`define VPE_SUB_CFG        2'h0
`define VPE_SUB_LVL        2'h1
`define VPE_SUB_DLY        2'h2

// ************************************************************
// field positions
// ************************************************************
`define VPE_CTRL_LRST_BIT  0
`define VPE_CFG_FUNC_LSB   0
`define VPE_CFG_RLY_LSB    4
`define VPE_CFG_CURVE_BIT  12
`define VPE_CFG_PH_LSB     16
`define VPE_LVL_PU_LSB     0
`define VPE_LVL_MIN_LSB    8
`define VPE_DLY_LSB        0
`define VPE_ST_OP_LSB      0
`define VPE_ST_LATCH_LSB   3
`define VPE_ST_TRIP_BIT    8
`define VPE_ST_ALARM_BIT   9
`define VPE_ST_RLY_LSB     10
`define VPE_ST_XFER_BIT    15

// ************************************************************
// ranges and reset values
// ************************************************************
`define VPE_LVL_MAX        8'h7d
`define VPE_DLY_MAX        16'hea60
`define VPE_NSV_PU_RST     8'h0a
`define VPE_UV_PU_RST      8'h4b
`define VPE_UV_MIN_RST     8'h1e
`define VPE_DLY_RST        16'h0014
`define VPE_RLY_RST        5'h00

`endif

//--- hw/vpe_pkg.sv
package vpe_pkg;

  typedef enum logic [2:0] {
    VPE_FN_DIS   = 3'h0,
    VPE_FN_TRIP  = 3'h1,
    VPE_FN_ALARM = 3'h2,
    VPE_FN_LATCH = 3'h3,
    VPE_FN_CTRL  = 3'h4
  } vpe_func_e;

  typedef enum logic [1:0] {
    VPE_PH_ANY1 = 2'h0,
    VPE_PH_ANY2 = 2'h1,
    VPE_PH_ALL3 = 2'h2
  } vpe_phases_e;

  typedef enum logic {
    VPE_CV_DEF = 1'b0,
    VPE_CV_INV = 1'b1
  } vpe_curve_e;

  typedef logic [7:0]  vpe_level_t;
  typedef logic [15:0] vpe_delay_t;

endpackage

//--- hw/vpe_elem_if.sv
`timescale 1ns/1ps
interface vpe_elem_if;
  import vpe_pkg::*;
  vpe_func_e   func;
  vpe_curve_e  curve;
  vpe_phases_e phases;
  vpe_level_t  pickup;
  vpe_level_t  minop;
  vpe_delay_t  delay;
  vpe_level_t  v [3];
  logic        operate;

  modport cfg  (output func, curve, phases, pickup, minop, delay, v, input operate);
  modport elem (input func, curve, phases, pickup, minop, delay, v, output operate);
endinterface

//--- hw/vpe_elem.sv
`timescale 1ns/1ps
module vpe_elem #(
  parameter bit OVER = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  vpe_elem_if.elem e
);
  import vpe_pkg::*;

  logic [2:0]  hit;
  logic [1:0]  n_hit;
  logic        cond;
  vpe_level_t  vmin;
  logic [23:0] thr;
  logic [23:0] inc;
  logic [23:0] acc_q;
  logic        op_q;

  // ************************************************************
  // per phase level compare
  // ************************************************************
  for (genvar i = 0; i < 3; i++) begin : g_ph
    // under mode: a phase counts only inside [minop, pickup); the inverse rate still uses the lowest of all three phases
    assign hit[i] = OVER ? (e.v[i] > e.pickup)
                         : ((e.v[i] < e.pickup) && (e.v[i] >= e.minop));
  end

  assign n_hit = 2'(hit[0]) + 2'(hit[1]) + 2'(hit[2]);
  assign vmin  = (e.v[0] < e.v[1]) ? ((e.v[0] < e.v[2]) ? e.v[0] : e.v[2])
                                   : ((e.v[1] < e.v[2]) ? e.v[1] : e.v[2]);

  always_comb begin
    unique case (e.phases)
      VPE_PH_ANY1: cond = (n_hit >= 2'd1);
      VPE_PH_ANY2: cond = (n_hit >= 2'd2);
      default:     cond = (n_hit == 2'd3);
    endcase
    if (e.func == VPE_FN_DIS) begin
      cond = 1'b0;
    end
  end

  // ************************************************************
  // timing: definite counts ticks up to delay; inverse sums (pu - vmin) per tick up to delay * pu
  // ************************************************************
  // integrating keeps the curve right while the voltage moves
  assign thr = (e.curve == VPE_CV_INV) ? 24'(e.delay * e.pickup) : 24'(e.delay);
  assign inc = (e.curve == VPE_CV_INV) ? 24'(e.pickup - vmin) : 24'h000001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 24'h000000;
    end else if (!cond) begin
      acc_q <= 24'h000000;
    end else if (tick && (acc_q < thr)) begin
      acc_q <= acc_q + inc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_q <= 1'b0;
    end else begin
      op_q <= cond && (acc_q >= thr);
    end
  end

  assign e.operate = op_q;

endmodule

//--- hw/vpe_top.sv
// Functional notes
// - neg-seq voltage operates after pickup exceeded delay
// - five functions; disabled never outputs
// - relay mask energizes aux relays three-seven
// - neg-seq pickup 0 to 1.25, 0.01 steps
// - neg-seq delay 0 to 6000 s, 0.1 s
// - undervoltage operates below pickup after delay
// - control use energizes relay while under
// - internal inhibits independent of undervoltage outputs
// - two identical independent bus undervoltage elements
// - curve selects definite or inverse; definite exact
// - inverse: delay over one minus ratio
// - undervoltage pickup 0 to 1.25, 0.01 steps
// - undervoltage delay 0 to 6000 s, 0.1 s
// - phases required: any one, two, all
// - minimum operating voltage inhibits below it
// - zero minimum lets dead bus operate
// - undervoltage operation issues a transfer signal
// - timer clears above pickup or below minimum
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "vpe_cfg.svh"
module vpe_top #(
  parameter int TICK_CYCLES = `VPE_TICK_CYCLES,
  parameter int ADDR_W      = 8
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire vpe_pkg::vpe_level_t  neg_seq_v,
  input  wire vpe_pkg::vpe_level_t  bus_va,
  input  wire vpe_pkg::vpe_level_t  bus_vb,
  input  wire vpe_pkg::vpe_level_t  bus_vc,
  output logic                      trip,
  output logic                      alarm,
  output logic [4:0]                aux_relay,
  output logic                      transfer
);
  import vpe_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ************************************************************
  // setting stores, index 0 neg-seq, 1 and 2 bus undervoltage
  // ************************************************************
  vpe_func_e    func_q   [3];
  logic [4:0]   rly_q    [3];
  vpe_curve_e   curve_q  [3];
  vpe_phases_e  ph_q     [3];
  vpe_level_t   pu_q     [3];
  vpe_level_t   min_q    [3];
  vpe_delay_t   dly_q    [3];
  logic [2:0]   latch_q;
  logic [2:0]   op;
  logic         tick_q;
  logic [TW-1:0] tcnt_q;

  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              do_wr;
  logic [31:0]       wmask;
  logic [31:0]       wr_old;
  logic [31:0]       wr_new;
  logic              wr_ok;
  logic              lrst;
  logic [31:0]       rd_word;
  logic              rd_ok;
  logic [31:0]       status;

  logic        trip_d;
  logic        alarm_d;
  logic [4:0]  rly_d;
  logic        xfer_d;

  // ************************************************************
  // 0.1 s time base
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tcnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tcnt_q == TW'(TICK_CYCLES - 1)) begin
      tcnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tcnt_q <= tcnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ************************************************************
  // register read and write decode
  // ************************************************************
  function automatic logic [31:0] cfg_word(input int k, input logic [1:0] sub);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (sub)
      `VPE_SUB_CFG: begin
        w[`VPE_CFG_FUNC_LSB +: 3] = func_q[k];
        w[`VPE_CFG_RLY_LSB +: 5]  = rly_q[k];
        w[`VPE_CFG_CURVE_BIT]     = curve_q[k];
        w[`VPE_CFG_PH_LSB +: 2]   = ph_q[k];
      end
      `VPE_SUB_LVL: begin
        w[`VPE_LVL_PU_LSB +: 8]  = pu_q[k];
        w[`VPE_LVL_MIN_LSB +: 8] = min_q[k];
      end
      default: w[`VPE_DLY_LSB +: 16] = dly_q[k];
    endcase
    return w;
  endfunction

  function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a, input logic [31:0] st,
                                           output logic ok);
    logic [7:0] o;
    o  = 8'(a);
    ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:0] == ADDR_W'(o));
    reg_read = 32'h0000_0000;
    if (o == `VPE_OFS_STATUS) begin
      reg_read = st;
    end else if (o == `VPE_OFS_CTRL) begin
      reg_read = 32'h0000_0000;
    end else if ((o[7:4] >= 4'h1) && (o[7:4] <= 4'h3) && (o[3:2] != 2'h3)) begin
      reg_read = cfg_word(int'(o[7:4]) - 1, o[3:2]);
    end else begin
      ok = 1'b0;
    end
  endfunction

  always_comb begin
    status = 32'h0000_0000;
    status[`VPE_ST_OP_LSB +: 3]    = op;
    status[`VPE_ST_LATCH_LSB +: 3] = latch_q;
    status[`VPE_ST_TRIP_BIT]       = trip;
    status[`VPE_ST_ALARM_BIT]      = alarm;
    status[`VPE_ST_RLY_LSB +: 5]   = aux_relay;
    status[`VPE_ST_XFER_BIT]       = transfer;
  end

  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wmask[8*b +: 8] = {8{wstrb_q[b]}};
  end

  assign do_wr  = aw_have_q && w_have_q && !s_axi_bvalid;

  // a function with an output argument must be called from a procedure
  always_comb begin
    wr_ok   = 1'b0;
    rd_ok   = 1'b0;
    wr_old  = reg_read(awaddr_q, status, wr_ok);
    rd_word = reg_read(s_axi_araddr, status, rd_ok);
  end

  assign wr_new = (wr_old & ~wmask) | (wdata_q & wmask);
  assign lrst   = do_wr && wr_ok && (8'(awaddr_q) == `VPE_OFS_CTRL) && wr_new[`VPE_CTRL_LRST_BIT];

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !do_wr;
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !do_wr;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // setting stores; out-of-range levels, delays and phases clamp to the top of range, functions to disabled
  // ************************************************************
  for (genvar k = 0; k < 3; k++) begin : g_set
    logic hit_k;
    assign hit_k = do_wr && wr_ok && (8'(awaddr_q[7:4]) == 8'(k + 1));
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        func_q[k]  <= VPE_FN_DIS;
        rly_q[k]   <= `VPE_RLY_RST;
        curve_q[k] <= VPE_CV_DEF;
        ph_q[k]    <= (k == 0) ? VPE_PH_ANY1 : VPE_PH_ALL3;
        pu_q[k]    <= (k == 0) ? `VPE_NSV_PU_RST : `VPE_UV_PU_RST;
        min_q[k]   <= (k == 0) ? 8'h00 : `VPE_UV_MIN_RST;
        dly_q[k]   <= `VPE_DLY_RST;
      end else if (hit_k) begin
        unique case (awaddr_q[3:2])
          `VPE_SUB_CFG: begin
            func_q[k] <= (wr_new[`VPE_CFG_FUNC_LSB +: 3] > 3'(VPE_FN_CTRL))
                         ? VPE_FN_DIS : vpe_func_e'(wr_new[`VPE_CFG_FUNC_LSB +: 3]);
            rly_q[k]  <= wr_new[`VPE_CFG_RLY_LSB +: 5];
            if (k != 0) begin
              curve_q[k] <= vpe_curve_e'(wr_new[`VPE_CFG_CURVE_BIT]);
              ph_q[k]    <= (wr_new[`VPE_CFG_PH_LSB +: 2] > 2'(VPE_PH_ALL3))
                            ? VPE_PH_ALL3 : vpe_phases_e'(wr_new[`VPE_CFG_PH_LSB +: 2]);
            end
          end
          `VPE_SUB_LVL: begin
            pu_q[k] <= (wr_new[`VPE_LVL_PU_LSB +: 8] > `VPE_LVL_MAX)
                       ? `VPE_LVL_MAX : wr_new[`VPE_LVL_PU_LSB +: 8];
            if (k != 0) begin
              min_q[k] <= (wr_new[`VPE_LVL_MIN_LSB +: 8] > `VPE_LVL_MAX)
                          ? `VPE_LVL_MAX : wr_new[`VPE_LVL_MIN_LSB +: 8];
            end
          end
          `VPE_SUB_DLY: begin
            dly_q[k] <= (wr_new[`VPE_DLY_LSB +: 16] > `VPE_DLY_MAX)
                        ? `VPE_DLY_MAX : wr_new[`VPE_DLY_LSB +: 16];
          end
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // protection elements
  // ************************************************************
  vpe_elem_if ei [3] ();

  for (genvar k = 0; k < 3; k++) begin : g_el
    assign ei[k].func   = func_q[k];
    assign ei[k].curve  = curve_q[k];
    assign ei[k].phases = ph_q[k];
    assign ei[k].pickup = pu_q[k];
    assign ei[k].minop  = min_q[k];
    assign ei[k].delay  = dly_q[k];
    assign ei[k].v[0]   = (k == 0) ? neg_seq_v : bus_va;
    assign ei[k].v[1]   = (k == 0) ? neg_seq_v : bus_vb;
    assign ei[k].v[2]   = (k == 0) ? neg_seq_v : bus_vc;
    assign op[k]        = ei[k].operate;

    // two bus instances share inputs, never settings
    vpe_elem #(
      .OVER (k == 0)
    ) u_elem (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick_q),
      .e       (ei[k])
    );

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        latch_q[k] <= 1'b0;
      end else if (op[k] && func_q[k] == VPE_FN_LATCH) begin
        latch_q[k] <= 1'b1;
      end else if (lrst || func_q[k] != VPE_FN_LATCH) begin
        latch_q[k] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // output combining
  // ************************************************************
  // element outputs fan out only to relays, trip/alarm, transfer and status, so
  // no internal inhibit can be derived from them
  always_comb begin
    trip_d  = 1'b0;
    alarm_d = 1'b0;
    rly_d   = 5'h00;
    xfer_d  = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (op[k] && func_q[k] == VPE_FN_TRIP) begin
        trip_d = 1'b1;
      end
      if ((op[k] && func_q[k] == VPE_FN_ALARM) || latch_q[k]) begin
        alarm_d = 1'b1;
      end
      if ((op[k] && func_q[k] != VPE_FN_DIS) || latch_q[k]) begin
        rly_d = rly_d | rly_q[k];
      end
      if (k != 0 && op[k] && func_q[k] != VPE_FN_DIS) begin
        xfer_d = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip      <= 1'b0;
      alarm     <= 1'b0;
      aux_relay <= 5'h00;
      transfer  <= 1'b0;
    end else begin
      trip      <= trip_d;
      alarm     <= alarm_d;
      aux_relay <= rly_d;
      transfer  <= xfer_d;
    end
  end

endmodule

//--- sim/vpe_top_properties.sv
`timescale 1ns/1ps
// ************************************************************
// port-level checks
// ************************************************************
module vpe_top_properties (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire vpe_pkg::vpe_level_t neg_seq_v,
  input wire vpe_pkg::vpe_level_t bus_va,
  input wire vpe_pkg::vpe_level_t bus_vb,
  input wire vpe_pkg::vpe_level_t bus_vc,
  input wire logic                trip,
  input wire logic                transfer
);
  import vpe_pkg::*;
  logic any_low;
  // highest legal pickup is 0x7d, so a phase at or above it never counts as under
  assign any_low = bus_va < 8'h7d || bus_vb < 8'h7d || bus_vc < 8'h7d;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before accept");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read data changed before accept");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during pending read");
  chk_xfer_cause: assert property (transfer |-> $past(any_low, 2))
    else $error("transfer without an under phase");
  chk_xfer_clear: assert property (!any_low |-> ##2 !transfer)
    else $error("transfer kept with all phases high");
  chk_idle_quiet: assert property (!any_low && neg_seq_v == 8'h00 |-> ##2 !trip)
    else $error("trip with no element condition");
endmodule

//--- sim/tb_vpe_top.sv
`timescale 1ns/1ps
`include "vpe_cfg.svh"
module tb_vpe_top;
  import vpe_pkg::*;
  localparam int         TK = 16;
  localparam logic [7:0] NS = `VPE_OFS_NSV_BASE;
  localparam logic [7:0] U1 = `VPE_OFS_UV1_BASE;
  localparam logic [7:0] U2 = `VPE_OFS_UV2_BASE;
  localparam logic [7:0] HI = 8'h80;
  localparam logic [7:0]  RA [9] = '{NS, NS + 8'h4, NS + 8'h8, U1, U1 + 8'h4, U1 + 8'h8, U2, U2 + 8'h4, U2 + 8'h8};
  localparam logic [31:0] RV [9] = '{32'h0, 32'h0a, 32'h14, 32'h20000, 32'h1e4b, 32'h14, 32'h20000, 32'h1e4b, 32'h14};
  localparam logic [7:0]  CA [6] = '{NS + 8'h4, NS + 8'h8, U1 + 8'h4, U1, U2 + 8'h8, U2 + 8'h4};
  localparam logic [31:0] CW [6] = '{32'hffff, 32'hffff, 32'hffff, 32'h31007, 32'hea61, 32'h7e7d};
  localparam logic [31:0] CR [6] = '{32'h7d, 32'hea60, 32'h7d7d, 32'h21000, 32'hea60, 32'h7d7d};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        trip, alarm, transfer;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [4:0]  aux_relay;
  vpe_level_t  neg_seq_v, bus_va, bus_vb, bus_vc;
  int          fails, n_tests;

  vpe_top #(.TICK_CYCLES(TK)) vpe_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .neg_seq_v, .bus_va, .bus_vb, .bus_vc, .trip, .alarm, .aux_relay, .transfer);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_of_test;
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tmo;
    fails++;
    end_of_test();
  endtask

  // bw holds off bready for a few edges to exercise a slow master
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int bw = 0);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (bw == 0);
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      s_axi_bready <= (n + 1 >= bw);
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 100) tmo();
  endtask

  task automatic rd(input logic [7:0] a, input int rw = 0);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (rw == 0);
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= (n + 1 >= rw);
    end
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 100) tmo();
  endtask

  task automatic setv(input vpe_level_t ns, input vpe_level_t a, input vpe_level_t b, input vpe_level_t c);
    @(posedge aclk);
    neg_seq_v <= ns;
    bus_va <= a;
    bus_vb <= b;
    bus_vc <= c;
  endtask

  // expected packs trip, alarm, relays 3..7, transfer
  task automatic outs(input string nm, input logic [7:0] e);
    repeat (4) @(posedge aclk);
    chk(nm, {24'h0, trip, alarm, aux_relay, transfer}, {24'h0, e});
  endtask

  function automatic logic [31:0] cfg(input logic [2:0] f, input logic [4:0] m, input logic cv, input logic [1:0] ph);
    return {14'h0, ph, 3'h0, cv, 3'h0, m, 1'b0, f};
  endfunction

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int i, f, ph, nl, cv, n;
    fails = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {neg_seq_v, bus_va, bus_vb, bus_vc} = {8'h00, HI, HI, HI};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 9; i++) begin
      rd(RA[i]);
      chk("reset value", rdat, RV[i]);
    end
    rd(`VPE_OFS_STATUS);
    chk("status idle", rdat, 32'h0);
    rd(8'hfc, 3);
    chk("unmapped read", {resp, rdat[29:0]}, 32'h80000000);
    wr(8'hfc, 32'h1, 3);
    chk("unmapped write", {30'h0, resp}, 32'h2);
    for (i = 0; i < 6; i++) begin
      wr(CA[i], CW[i]);
      rd(CA[i]);
      chk("range clamp", rdat, CR[i]);
    end
    // negative sequence element through every function
    wr(NS + 8'h4, 32'h0a);
    wr(NS + 8'h8, 32'h0);
    for (f = 0; f < 5; f++) begin
      wr(NS, cfg(f[2:0], 5'h15, 1'b0, 2'h0));
      setv(8'h20, HI, HI, HI);
      outs("nsv over", {f == 1, f == 2 || f == 3, (f != 0) ? 5'h15 : 5'h00, 1'b0});
      setv(8'h0a, HI, HI, HI);
      outs("nsv at pickup", {1'b0, f == 3, (f == 3) ? 5'h15 : 5'h00, 1'b0});
      wr(`VPE_OFS_CTRL, 32'h1);
      outs("nsv cleared", 8'h00);
    end
    wr(NS, 32'h0);
    // phase count on bus element one
    wr(U1 + 8'h4, 32'h1e4b);
    wr(U1 + 8'h8, 32'h0);
    for (ph = 0; ph < 3; ph++) begin
      wr(U1, cfg(3'h1, 5'h01, 1'b0, ph[1:0]));
      for (nl = 1; nl < 4; nl++) begin
        setv(8'h0, 8'h40, (nl > 1) ? 8'h40 : HI, (nl > 2) ? 8'h40 : HI);
        outs("uv phases", {nl > ph, 1'b0, (nl > ph) ? 5'h01 : 5'h00, nl > ph});
      end
    end
    setv(8'h0, 8'h4b, 8'h4b, 8'h4b);
    outs("uv at pickup", 8'h00);
    setv(8'h0, 8'h1d, 8'h1d, 8'h1d);
    outs("uv below minimum", 8'h00);
    setv(8'h0, 8'h1e, 8'h1e, 8'h1e);
    outs("uv at minimum", 8'h83);
    wr(U1 + 8'h4, 32'h004b);
    setv(8'h0, 8'h0, 8'h0, 8'h0);
    outs("uv dead bus", 8'h83);
    // second bus element in control use, first one disabled
    wr(U1, cfg(3'h0, 5'h01, 1'b0, 2'h2));
    wr(U2 + 8'h4, 32'h1e4b);
    wr(U2 + 8'h8, 32'h0);
    wr(U2, cfg(3'h4, 5'h10, 1'b0, 2'h2));
    setv(8'h0, 8'h40, 8'h40, 8'h40);
    outs("uv2 control", 8'h21);
    wr(U2, 32'h0);
    outs("uv2 disabled", 8'h00);
    // operate time: definite, inverse at zero volts, inverse at half pickup
    wr(U1 + 8'h8, 32'h3);
    for (cv = 0; cv < 3; cv++) begin
      setv(8'h0, HI, HI, HI);
      wr(U1, cfg(3'h1, 5'h00, cv != 0, 2'h2));
      setv(8'h0, (cv == 2) ? 8'h26 : 8'h0, (cv == 2) ? 8'h26 : 8'h0, (cv == 2) ? 8'h26 : 8'h0);
      for (n = 0; n < 10 * TK && trip !== 1'b1; n++) @(posedge aclk);
      if (n == 10 * TK) tmo();
      // the tick runs free, so the first counted tick may come anywhere from one cycle to TK cycles after the condition
      chk("operate time", {31'h0, n >= ((cv == 2) ? 6 : 2) * TK && n <= ((cv == 2) ? 8 : 4) * TK + 4}, 32'h1);
    end
    setv(8'h0, HI, HI, HI);
    outs("uv released", 8'h00);
    end_of_test();
  end
endmodule

bind vpe_top vpe_top_properties vpe_top_properties_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .neg_seq_v, .bus_va, .bus_vb, .bus_vc, .trip,
  .transfer);
